// file: crie_consts.svh
// Register offsets, field positions, reset values and state thresholds of the receive interrupt block.
`ifndef CRIE_CONSTS_SVH
`define CRIE_CONSTS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define CRIE_ADDR_W        4
`define CRIE_OFF_ENABLES   4'h0
`define CRIE_OFF_FLAGS     4'h1
`define CRIE_OFF_IRQ_STAT  4'h2
`define CRIE_OFF_IRQ_MASK  4'h3

// ****************************************************************
// Enable register fields
// ****************************************************************
`define CRIE_BIT_WAKE_IE   7
`define CRIE_BIT_CSC_IE    6
`define CRIE_RSENS_HI      5
`define CRIE_RSENS_LO      4
`define CRIE_TSENS_HI      3
`define CRIE_TSENS_LO      2
`define CRIE_BIT_OVR_IE    1
`define CRIE_BIT_RXF_IE    0
`define CRIE_ENABLES_RST   8'h00
`define CRIE_SENS_MASK     8'h3C

// ****************************************************************
// Flag register fields
// ****************************************************************
`define CRIE_BIT_WAKE_F    7
`define CRIE_BIT_CSC_F     6
`define CRIE_RX_STATE_INDICATOR_HI      5
`define CRIE_RX_STATE_INDICATOR_LO      4
`define CRIE_TX_STATE_INDICATOR_HI      3
`define CRIE_TX_STATE_INDICATOR_LO      2
`define CRIE_BIT_OVR_F     1
`define CRIE_BIT_RXF_F     0
`define CRIE_EVT_RST       4'h0

// ****************************************************************
// Error counter thresholds
// ****************************************************************
`define CRIE_WARN_LIMIT    9'd96
`define CRIE_ERR_LIMIT     9'd127
`define CRIE_BOFF_LIMIT    9'd255

`endif

// file: crie_pkg.sv
// Types shared by the receive interrupt block.
package crie_pkg;

    typedef enum logic [1:0] {
        CRIE_ST_OK   = 2'b00,
        CRIE_ST_WARN = 2'b01,
        CRIE_ST_ERR  = 2'b10,
        CRIE_ST_BOFF = 2'b11
    } crie_state_type;

    typedef enum logic [1:0] {
        CRIE_SENS_NONE = 2'b00,
        CRIE_SENS_BOFF = 2'b01,
        CRIE_SENS_ERR  = 2'b10,
        CRIE_SENS_ALL  = 2'b11
    } crie_sens_type;

endpackage

// file: crie_rx_irq_enable.sv
// Receive interrupt enable register, receive flags and interrupt request gating.
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`include "crie_consts.svh"

//
// Behaviour
// - Init mode holds non-sensitivity enables at reset value.
// - Writes only outside init; reads anytime.
// - Sensitivity fields survive init mode.
// - Wake enable gates wake interrupt request.
// - Status-change enable gates error request.
// - Receiver sensitivity selects reported transitions.
// - Transmitter sensitivity uses same encoding.
// - Indicators update only with no pending change.
// - Overrun enable gates error request.
// - Receive-full enable gates receive request.
// - Cleared enable blocks request, flag still works.
// - State from counters: 96, 127, 255 limits.
// - Flags set by hardware, pending while enabled.
module crie_rx_irq_enable
    import crie_pkg::*;
(
    input  wire logic                     clk_sys,
    input  wire logic                     rst_n,
    input  wire logic [`CRIE_ADDR_W-1:0]  reg_addr,
    input  wire logic [31:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [31:0]              reg_rdata,
    input  wire logic                     init_request,
    input  wire logic                     init_acknowledge,
    input  wire logic                     wake_event,
    input  wire logic                     overrun_event,
    input  wire logic                     rx_full_event,
    input  wire logic                     rx_full_release,
    input  wire logic [7:0]               rx_error_count,
    input  wire logic [8:0]               tx_error_count,
    output logic                          wake_irq,
    output logic                          error_irq,
    output logic                          rx_irq,
    output logic                          block_irq
);

    // ****************************************************************
    // Decode
    // ****************************************************************
    logic       init_mode;
    logic       write_ok;
    logic       wr_en;
    logic       wr_flags;
    logic       wr_stat;
    logic       wr_mask;
    logic [7:0] receiver_interrupt_enables_q;
    logic [7:0] receiver_flag_register;
    logic       wake_event_flag_q;
    logic       status_change_flag_q;
    logic       overrun_flag_q;
    logic       rx_full_flag_q;
    logic [1:0] rx_state_indicator_q;
    logic [1:0] tx_state_indicator_q;
    logic [3:0] irq_stat_q;
    logic [3:0] irq_mask_q;
    logic [3:0] irq_events;
    crie_state_type rx_now;
    crie_state_type tx_now;
    crie_state_type rx_prev_q;
    crie_state_type tx_prev_q;
    logic       rx_hit;
    logic       tx_hit;
    logic       csc_set;
    logic [7:0] receiver_interrupt_enables_d;
    logic       wake_clr;
    logic       csc_clr;
    logic       ovr_clr;
    logic       rxf_clr;
    logic [3:0] stat_clr;
    logic [31:0] reg_rdata_d;

    // In the two half-way states of the init handshake the enables are
    // neither forced to reset nor open to writes.
    assign init_mode = init_request && init_acknowledge;
    assign write_ok  = !init_request && !init_acknowledge;
    assign wr_en     = reg_wr && (reg_addr == `CRIE_OFF_ENABLES) && write_ok;
    assign wr_flags  = reg_wr && (reg_addr == `CRIE_OFF_FLAGS);
    assign wr_stat   = reg_wr && (reg_addr == `CRIE_OFF_IRQ_STAT);
    assign wr_mask   = reg_wr && (reg_addr == `CRIE_OFF_IRQ_MASK);

    // ****************************************************************
    // Enable register
    // ****************************************************************
    // The sensitivity fields keep their value through init so that the
    // error reporting policy need not be reprogrammed after a re-init.
    always_comb begin
        receiver_interrupt_enables_d = receiver_interrupt_enables_q;
        if (init_mode) begin
            receiver_interrupt_enables_d = (receiver_interrupt_enables_q & `CRIE_SENS_MASK)
                | (`CRIE_ENABLES_RST & ~`CRIE_SENS_MASK);
        end else if (wr_en) begin
            receiver_interrupt_enables_d = reg_wdata[7:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            receiver_interrupt_enables_q <= `CRIE_ENABLES_RST;
        end else begin
            receiver_interrupt_enables_q <= receiver_interrupt_enables_d;
        end
    end

    // ****************************************************************
    // Error state derivation
    // ****************************************************************
    // A transmitter in bus-off drags the receiver state with it, and the
    // receiver leaves bus-off only when the transmitter does.
    always_comb begin
        if (tx_error_count > `CRIE_BOFF_LIMIT) begin
            rx_now = CRIE_ST_BOFF;
            tx_now = CRIE_ST_BOFF;
        end else begin
            if ({1'b0, rx_error_count} > `CRIE_ERR_LIMIT) begin
                rx_now = CRIE_ST_ERR;
            end else if ({1'b0, rx_error_count} > `CRIE_WARN_LIMIT) begin
                rx_now = CRIE_ST_WARN;
            end else begin
                rx_now = CRIE_ST_OK;
            end
            if (tx_error_count > `CRIE_ERR_LIMIT) begin
                tx_now = CRIE_ST_ERR;
            end else if (tx_error_count > `CRIE_WARN_LIMIT) begin
                tx_now = CRIE_ST_WARN;
            end else begin
                tx_now = CRIE_ST_OK;
            end
        end
    end

    // Encoding 10 takes any change into or out of error or bus-off; both of
    // those states carry the high bit.
    function automatic logic sens_hit(input logic [1:0] sens, input crie_state_type old_s,
                                      input crie_state_type new_s);
        logic diff;
        diff = (old_s != new_s);
        case (sens)
            CRIE_SENS_NONE: sens_hit = 1'b0;
            CRIE_SENS_BOFF: sens_hit = diff && ((old_s == CRIE_ST_BOFF) || (new_s == CRIE_ST_BOFF));
            CRIE_SENS_ERR:  sens_hit = diff && (old_s[1] || new_s[1]);
            CRIE_SENS_ALL:  sens_hit = diff;
            default:        sens_hit = 1'b0;
        endcase
    endfunction

    assign rx_hit  = sens_hit(receiver_interrupt_enables_q[`CRIE_RSENS_HI:`CRIE_RSENS_LO],
                              rx_prev_q, rx_now);
    assign tx_hit  = sens_hit(receiver_interrupt_enables_q[`CRIE_TSENS_HI:`CRIE_TSENS_LO],
                              tx_prev_q, tx_now);
    assign csc_set = rx_hit || tx_hit;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_prev_q <= CRIE_ST_OK;
        end else begin
            rx_prev_q <= rx_now;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_prev_q <= CRIE_ST_OK;
        end else begin
            tx_prev_q <= tx_now;
        end
    end

    // Indicators are frozen while a status change is pending so that
    // software reads the state that caused the interrupt.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_state_indicator_q <= CRIE_ST_OK;
        end else if (!status_change_flag_q) begin
            rx_state_indicator_q <= rx_now;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_state_indicator_q <= CRIE_ST_OK;
        end else if (!status_change_flag_q) begin
            tx_state_indicator_q <= tx_now;
        end
    end

    // ****************************************************************
    // Event flags, write one to clear, set wins
    // ****************************************************************
    // A clear that meets a new event in the same cycle loses, so an event
    // that software has not yet seen is never dropped.
    assign wake_clr = wr_flags && reg_wdata[`CRIE_BIT_WAKE_F];
    assign csc_clr  = wr_flags && reg_wdata[`CRIE_BIT_CSC_F];
    assign ovr_clr  = wr_flags && reg_wdata[`CRIE_BIT_OVR_F];
    assign rxf_clr  = (wr_flags && reg_wdata[`CRIE_BIT_RXF_F]) || rx_full_release;

    crie_sticky_bits #(
        .WIDTH (1)
    ) wake_flag_i (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .set_in   (wake_event),
        .clear_in (wake_clr),
        .bits_q   (wake_event_flag_q)
    );

    crie_sticky_bits #(
        .WIDTH (1)
    ) csc_flag_i (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .set_in   (csc_set),
        .clear_in (csc_clr),
        .bits_q   (status_change_flag_q)
    );

    crie_sticky_bits #(
        .WIDTH (1)
    ) ovr_flag_i (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .set_in   (overrun_event),
        .clear_in (ovr_clr),
        .bits_q   (overrun_flag_q)
    );

    crie_sticky_bits #(
        .WIDTH (1)
    ) rxf_flag_i (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .set_in   (rx_full_event),
        .clear_in (rxf_clr),
        .bits_q   (rx_full_flag_q)
    );

    assign receiver_flag_register = {wake_event_flag_q, status_change_flag_q,
                                     rx_state_indicator_q, tx_state_indicator_q,
                                     overrun_flag_q, rx_full_flag_q};

    // ****************************************************************
    // Request gating
    // ****************************************************************
    // Requests follow the flag and enable flops directly, so an enable set
    // while its flag stands raises the request in the next cycle.
    always_comb begin
        wake_irq  = wake_event_flag_q && receiver_interrupt_enables_q[`CRIE_BIT_WAKE_IE];
        error_irq = (status_change_flag_q && receiver_interrupt_enables_q[`CRIE_BIT_CSC_IE])
                 || (overrun_flag_q && receiver_interrupt_enables_q[`CRIE_BIT_OVR_IE]);
        rx_irq    = rx_full_flag_q && receiver_interrupt_enables_q[`CRIE_BIT_RXF_IE];
    end

    // ****************************************************************
    // Block interrupt status and mask
    // ****************************************************************
    assign irq_events = {wake_event, csc_set, overrun_event, rx_full_event};

    assign stat_clr = {4{wr_stat}} & reg_wdata[3:0];

    crie_sticky_bits #(
        .WIDTH (4)
    ) irq_stat_i (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .set_in   (irq_events),
        .clear_in (stat_clr),
        .bits_q   (irq_stat_q)
    );

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask_q <= `CRIE_EVT_RST;
        end else if (wr_mask) begin
            irq_mask_q <= reg_wdata[3:0];
        end
    end

    // The mask only gates the shared output; status bits record every event
    // whether it is masked or not.
    assign block_irq = |(irq_stat_q & irq_mask_q);

    // ****************************************************************
    // Read port
    // ****************************************************************
    // Idle cycles return zero, so a stale value never passes for an answer.
    always_comb begin
        reg_rdata_d = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                `CRIE_OFF_ENABLES:  reg_rdata_d = {24'h00_0000, receiver_interrupt_enables_q};
                `CRIE_OFF_FLAGS:    reg_rdata_d = {24'h00_0000, receiver_flag_register};
                `CRIE_OFF_IRQ_STAT: reg_rdata_d = {28'h000_0000, irq_stat_q};
                `CRIE_OFF_IRQ_MASK: reg_rdata_d = {28'h000_0000, irq_mask_q};
                default:            reg_rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= reg_rdata_d;
        end
    end

endmodule

// ****************************************************************
// Sticky event bits
// ****************************************************************
// Each bit is set in any cycle in which its event input is high and is
// cleared only by its clear input; when both come in one cycle the set
// wins.
module crie_sticky_bits
    import crie_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input  wire logic [WIDTH-1:0] set_in,
    input  wire logic [WIDTH-1:0] clear_in,
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    output logic      [WIDTH-1:0] bits_q
);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bits_q <= '0;
        end else begin
            bits_q <= set_in | (bits_q & ~clear_in);
        end
    end

endmodule

// file: crie_rx_irq_enable_asserts.sv
// Concurrent checks on the ports of the receive interrupt enable block.
`timescale 1ns/10ps
`include "crie_consts.svh"
module crie_chk
    import crie_pkg::*;
(
    input wire logic                    clk_sys,
    input wire logic                    rst_n,
    input wire logic [`CRIE_ADDR_W-1:0] reg_addr,
    input wire logic [31:0]             reg_wdata,
    input wire logic                    reg_wr,
    input wire logic                    reg_rd,
    input wire logic [31:0]             reg_rdata,
    input wire logic                    init_request,
    input wire logic                    init_acknowledge,
    input wire logic                    wake_event,
    input wire logic                    overrun_event,
    input wire logic                    rx_full_event,
    input wire logic [8:0]              tx_error_count,
    input wire logic                    wake_irq,
    input wire logic                    error_irq,
    input wire logic                    rx_irq
);
    // ****************************************************************
    // Shadow of the enable register
    // ****************************************************************
    logic [7:0] en_q;
    wire ini = init_request && init_acknowledge;
    wire quiet = !reg_wr && !init_request && !init_acknowledge;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            en_q <= 8'h00;
        else if (ini)
            en_q <= en_q & `CRIE_SENS_MASK;
        else if (reg_wr && reg_addr == `CRIE_OFF_ENABLES && !init_request && !init_acknowledge)
            en_q <= reg_wdata[7:0];
    end
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence boff_armed;
        en_q[6] && en_q[3:2] == 2'b01 && tx_error_count <= 9'd255;
    endsequence
    sequence boff_entry;
        boff_armed ##1 tx_error_count > 9'd255;
    endsequence
    AST_INIT_CLEAR: assert property (ini |=> !wake_irq && !error_irq && !rx_irq)
        else $error("irq output high while init forces enables off");
    AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == '0)
        else $error("read data not zero outside read answer");
    AST_RD_EN: assert property (reg_rd && reg_addr == `CRIE_OFF_ENABLES |=> reg_rdata == {24'h0, $past(en_q)})
        else $error("enable readback differs from shadow");
    AST_WAKE: assert property (wake_event && en_q[7] && quiet |=> wake_irq)
        else $error("wake event did not raise wake irq");
    AST_OVR: assert property (overrun_event && en_q[1] && quiet |=> error_irq)
        else $error("overrun event did not raise error irq");
    AST_RXF: assert property (rx_full_event && en_q[0] && quiet |=> rx_irq)
        else $error("receive full event did not raise rx irq");
    AST_GATE_WAKE: assert property (wake_irq |-> en_q[7])
        else $error("wake irq with enable cleared");
    AST_GATE_ERR: assert property (error_irq |-> en_q[6] || en_q[1])
        else $error("error irq with both enables cleared");
    AST_GATE_RX: assert property (rx_irq |-> en_q[0])
        else $error("rx irq with enable cleared");
    AST_CSC: assert property (boff_entry |-> ##[1:3] error_irq)
        else $error("bus-off entry did not raise error irq");
endmodule

bind crie_rx_irq_enable crie_chk crie_chk_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .init_request(init_request), .init_acknowledge(init_acknowledge),
    .wake_event(wake_event), .overrun_event(overrun_event), .rx_full_event(rx_full_event),
    .tx_error_count(tx_error_count), .wake_irq(wake_irq), .error_irq(error_irq),
    .rx_irq(rx_irq));

// file: crie_rx_irq_enable_bench.sv
// Self-checking bench for the receive interrupt enable block.
`timescale 1ns/10ps
module crie_rx_irq_enable_bench;
    logic        clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, rd_seen = 0;
    logic        init_request = 0, init_acknowledge = 0, rel = 0;
    logic        wake_irq, error_irq, rx_irq, block_irq;
    logic [3:0]  reg_addr = '0;
    logic [31:0] reg_wdata = '0, reg_rdata;
    logic [2:0]  evt = '0;
    logic [7:0]  rx_cnt = '0, v;
    logic [8:0]  tx_cnt = '0;
    logic [31:0] exp_q[$];
    int          fails = 0, comparisons = 0;
    // Per event: flag and enable bit, status bit, irq output pattern.
    logic [7:0]  fb[3] = '{8'h80, 8'h02, 8'h01};
    logic [3:0]  sb[3] = '{4'h8, 4'h2, 4'h1};
    logic [3:0]  ob[3] = '{4'h8, 4'h4, 4'h2};
    always #2.5 clk_sys = ~clk_sys;
    crie_rx_irq_enable crie_rx_irq_enable_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .init_request(init_request),
        .init_acknowledge(init_acknowledge), .wake_event(evt[2]), .overrun_event(evt[1]),
        .rx_full_event(evt[0]), .rx_full_release(rel), .rx_error_count(rx_cnt),
        .tx_error_count(tx_cnt), .wake_irq(wake_irq), .error_irq(error_irq),
        .rx_irq(rx_irq), .block_irq(block_irq));
    task automatic check(string n, logic [31:0] s, logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 0;
    endtask
    task automatic rd(logic [3:0] a, logic [31:0] e);
        @(posedge clk_sys);
        reg_rd <= 1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge clk_sys);
        reg_rd <= 0;
    endtask
    task automatic irq(logic [3:0] e);
        @(negedge clk_sys);
        check("irq", {28'h0, wake_irq, error_irq, rx_irq, block_irq}, {28'h0, e});
    endtask
    task automatic pulse(logic [2:0] e);
        @(posedge clk_sys);
        evt <= e;
        @(posedge clk_sys);
        evt <= '0;
    endtask
    task stop_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Read data stands only in the cycle after the strobe, so it is taken there.
    always @(posedge clk_sys) rd_seen <= reg_rd;
    always @(negedge clk_sys) if (rd_seen) check("reg_rdata", reg_rdata, exp_q.pop_front());
    initial begin
        repeat (5000) @(posedge clk_sys);
        fails++;
        stop_test;
    end
    initial begin
        void'($urandom(77));
        repeat (20) @(posedge clk_sys);
        rst_n <= 1;
        for (int a = 0; a < 4; a++) rd(a[3:0], '0);
        rd(4'h9, '0);
        $display("test reset done");
        v = 8'($urandom);
        wr(4'h0, {24'h0, v});
        wr(4'h9, 32'hFFFF_FFFF);
        rd(4'h0, {24'h0, v});
        @(posedge clk_sys) init_request <= 1;
        wr(4'h0, 32'h0000_00FF);
        rd(4'h0, {24'h0, v});
        @(posedge clk_sys) init_acknowledge <= 1;
        wr(4'h0, 32'h0000_00FF);
        rd(4'h0, {24'h0, v & 8'h3C});
        irq(4'h0);
        @(posedge clk_sys) {init_request, init_acknowledge} <= 2'b00;
        $display("test init done");
        for (int i = 0; i < 3; i++) begin
            wr(4'h0, '0);
            wr(4'h3, {28'h0, sb[i]});
            pulse(3'b100 >> i);
            irq(4'h1);
            rd(4'h1, {24'h0, fb[i]});
            rd(4'h2, {28'h0, sb[i]});
            wr(4'h0, {24'h0, fb[i]});
            pulse(3'b100 >> i);
            irq(ob[i] | 4'h1);
            wr(4'h1, {24'h0, fb[i]});
            wr(4'h2, 32'h0000_000F);
            irq(4'h0);
        end
        $display("test events done");
        // A release in the same cycle as the receive-full event loses to the set; a later release clears the flag.
        wr(4'h0, 32'h0000_0001);
        @(posedge clk_sys) {evt, rel} <= 4'b0011;
        @(posedge clk_sys) {evt, rel} <= 4'b0000;
        irq(4'h3);
        @(posedge clk_sys) rel <= 1'b1;
        @(posedge clk_sys) rel <= 1'b0;
        irq(4'h1);
        rd(4'h1, 32'h0000_0000);
        wr(4'h2, 32'h0000_000F);
        irq(4'h0);
        $display("test release done");
        wr(4'h0, 32'h0000_0044);
        @(posedge clk_sys) tx_cnt <= 9'd200;
        repeat (3) @(posedge clk_sys);
        rd(4'h1, 32'h0000_0008);
        @(posedge clk_sys) tx_cnt <= 9'd300;
        repeat (3) @(posedge clk_sys);
        rd(4'h1, 32'h0000_007C);
        irq(4'h4);
        @(posedge clk_sys) tx_cnt <= 9'd0;
        repeat (3) @(posedge clk_sys);
        rd(4'h1, 32'h0000_007C);
        wr(4'h1, 32'h0000_0040);
        wr(4'h2, 32'h0000_000F);
        rd(4'h1, 32'h0000_0000);
        wr(4'h0, 32'h0000_0068);
        @(posedge clk_sys) rx_cnt <= 8'd100;
        repeat (3) @(posedge clk_sys);
        rd(4'h1, 32'h0000_0010);
        @(posedge clk_sys) rx_cnt <= 8'd200;
        repeat (3) @(posedge clk_sys);
        rd(4'h1, 32'h0000_0060);
        wr(4'h1, 32'h0000_0040);
        wr(4'h0, 32'h0000_0040);
        @(posedge clk_sys) rx_cnt <= 8'd50;
        repeat (3) @(posedge clk_sys);
        rd(4'h1, 32'h0000_0000);
        wr(4'h0, 32'h0000_007C);
        @(posedge clk_sys) rx_cnt <= 8'd96;
        repeat (3) @(posedge clk_sys);
        rd(4'h1, 32'h0000_0000);
        @(posedge clk_sys) rx_cnt <= 8'd97;
        repeat (3) @(posedge clk_sys);
        rd(4'h1, 32'h0000_0050);
        irq(4'h4);
        $display("test status done");
        repeat (2) @(posedge clk_sys);
        stop_test;
    end
endmodule
